// file: rtl/mit_pkg.sv
package mit_pkg;

   // Buffered rapid-succession image slots; no figure given, plain default
   localparam int unsigned MIT_MAX_IMAGES_DEF = 4;
   localparam int unsigned MIT_SYNC_STAGES    = 3;
   localparam logic        MIT_READY_RST      = 1'b0;
   localparam logic        MIT_ERROR_RST      = 1'b0;

   typedef enum logic [1:0]
   {
      MIT_ACQ_READY  = 2'b00,
      MIT_ACQ_EXPOSE = 2'b01,
      MIT_ACQ_LOAD   = 2'b11
   } mit_acq_t;

   typedef enum logic [1:0]
   {
      MIT_PROC_IDLE = 2'b00,
      MIT_PROC_XFER = 2'b01,
      MIT_PROC_CONV = 2'b11,
      MIT_PROC_MEAS = 2'b10
   } mit_proc_t;

endpackage : mit_pkg

// file: rtl/mit_buf_if.sv
`timescale 1ns/1ps
`default_nettype none

interface mit_buf_if;
   logic img_ready;
   logic img_take;
   logic busy;
   logic done;

   modport acq
   (
      output img_ready,
      input  img_take,
      input  busy,
      input  done
   );

   modport proc
   (
      input  img_ready,
      output img_take,
      output busy,
      output done
   );
endinterface : mit_buf_if

`default_nettype wire

// file: rtl/mit_proc_seq.sv
`timescale 1ns/1ps
`default_nettype none

module mit_proc_seq
   import mit_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic reset_n,
   mit_buf_if.proc   buf_bus,
   output logic      xfer_start,
   input  wire logic xfer_done_in,
   output logic      conv_start,
   input  wire logic conv_done_in,
   output logic      meas_start,
   input  wire logic meas_done_in
);

   typedef struct packed
   {
      mit_proc_t ph;
      logic      take;
      logic      xfer;
      logic      conv;
      logic      meas;
      logic      done;
   } mit_seq_state_t;

   mit_seq_state_t st;
   mit_seq_state_t next_st;

   always_comb
   begin
      next_st      = st;
      next_st.take = 1'b0;
      next_st.xfer = 1'b0;
      next_st.conv = 1'b0;
      next_st.meas = 1'b0;
      next_st.done = 1'b0;
      case (st.ph)
         MIT_PROC_IDLE:
         begin
            if (buf_bus.img_ready)
            begin
               next_st.take = 1'b1;
               next_st.xfer = 1'b1; // RULE11
               next_st.ph   = MIT_PROC_XFER;
            end
         end
         MIT_PROC_XFER:
         begin
            if (xfer_done_in)
            begin
               next_st.conv = 1'b1; // RULE11
               next_st.ph   = MIT_PROC_CONV;
            end
         end
         MIT_PROC_CONV:
         begin
            if (conv_done_in)
            begin
               next_st.meas = 1'b1; // RULE11
               next_st.ph   = MIT_PROC_MEAS;
            end
         end
         MIT_PROC_MEAS:
         begin
            if (meas_done_in)
            begin
               next_st.done = 1'b1;
               next_st.ph   = MIT_PROC_IDLE;
            end
         end
         default:
         begin
            next_st.ph = MIT_PROC_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         st <= '{ph: MIT_PROC_IDLE, default: 1'b0};
      end
      else
      begin
         st <= next_st;
      end
   end

   assign buf_bus.img_take = st.take;
   assign buf_bus.busy     = (st.ph != MIT_PROC_IDLE);
   assign buf_bus.done     = st.done;
   assign xfer_start       = st.xfer;
   assign conv_start       = st.conv;
   assign meas_start       = st.meas;

   property p_xfer_then_conv;
      @(posedge sys_clk) disable iff (!reset_n)
      (st.ph == MIT_PROC_XFER) && xfer_done_in |=> conv_start ##1 !conv_start;
   endproperty
   a_xfer_then_conv: assert property (p_xfer_then_conv) else $error("conversion did not follow transfer"); // RULE11

   property p_conv_then_meas;
      @(posedge sys_clk) disable iff (!reset_n)
      meas_start |-> $past(st.ph == MIT_PROC_CONV) && $past(conv_done_in);
   endproperty
   a_conv_then_meas: assert property (p_conv_then_meas) else $error("measurement began before conversion"); // RULE11

endmodule : mit_proc_seq

`default_nettype wire

// file: rtl/mit_trigger_top.sv
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// (RULE1) Overlap mode: ready returns once image loading ends, not processing.
// (RULE2) Camera acquisition of a new trigger runs while previous image is processed.
// (RULE3) Pulse exposure-done when camera exposure completes; length set by shutter.
// (RULE4) Ready goes active once the image sits fully in the camera buffer.
// (RULE5) Triggers accepted only while ready; controller waits for ready first.
// (RULE6) With all image slots used, ready stays low until current processing ends.
// (RULE7) Error output rises when a trigger arrives while ready is low.
// (RULE8) Fieldbus controller gates triggers on the trigger-ready status bit.
// (RULE9) Controller limits trigger rate; excess triggers may be skipped.
// (RULE10) No overlap for multi-camera, HDR, repeated unit, serial triggers, built-in light.
// (RULE11) Loaded image moves to main memory, then RGB conversion, then measurement.
// (RULE12) Ready drops on accepting a trigger until its image is loaded.
module mit_trigger_top
   import mit_pkg::*;
#(
   parameter int unsigned MAX_IMAGES = MIT_MAX_IMAGES_DEF
)
(
   input  wire logic sys_clk,
   input  wire logic reset_n,
   input  wire logic step_pin,
   input  wire logic cmd_trigger,
   input  wire logic exposure_pin,
   input  wire logic load_done_in,
   input  wire logic overlap_enable,
   input  wire logic multi_camera_flow,
   input  wire logic hdr_flow,
   input  wire logic repeated_unit_flow,
   input  wire logic serial_trigger_src,
   input  wire logic builtin_light,
   input  wire logic error_clear,
   output logic      ready,
   output logic      trigger_ready_status,
   output logic      error_out,
   output logic      exposure_start,
   output logic      exposure_done_out,
   output logic      overlap_active,
   output logic      xfer_start,
   input  wire logic xfer_done_in,
   output logic      conv_start,
   input  wire logic conv_done_in,
   output logic      meas_start,
   input  wire logic meas_done_in
);

   localparam int unsigned CW = $clog2(MAX_IMAGES + 1);
   localparam logic [CW-1:0] CNT_MAX = CW'(MAX_IMAGES);

   typedef struct packed
   {
      mit_acq_t                   acq;
      logic [MIT_SYNC_STAGES-1:0] step_sync;
      logic [MIT_SYNC_STAGES-1:0] exp_sync;
      logic                       step_lvl;
      logic                       exp_lvl;
      logic [CW-1:0]              count;
      logic                       full;
      logic                       err;
      logic                       exp_start;
      logic                       exp_done;
   } mit_top_state_t;

   mit_top_state_t st;
   mit_top_state_t next_st;

   mit_buf_if buf_bus ();

   logic ovl_ok;
   logic step_rise;
   logic exp_rise;
   logic trig;
   logic accept;
   logic loaded;

   // A filtered level only moves once the last two stages agree
   function automatic logic mit_rise(input logic [MIT_SYNC_STAGES-1:0] s, input logic lvl);
      mit_rise = (s[1] == s[2]) && s[2] && !lvl;
   endfunction : mit_rise

   assign ovl_ok = overlap_enable && !(multi_camera_flow || hdr_flow || repeated_unit_flow ||
                                       serial_trigger_src || builtin_light); // RULE10

   assign step_rise = mit_rise(st.step_sync, st.step_lvl);
   assign exp_rise  = mit_rise(st.exp_sync, st.exp_lvl);
   assign trig      = step_rise || cmd_trigger;
   assign loaded    = (st.acq == MIT_ACQ_LOAD) && load_done_in;

   // Without overlap the whole chain must drain before the next trigger
   always_comb
   begin
      if (st.acq != MIT_ACQ_READY)
      begin
         ready = 1'b0; // RULE12
      end
      else if (ovl_ok)
      begin
         ready = !st.full && (st.count < CNT_MAX); // RULE1 RULE6
      end
      else
      begin
         ready = (st.count == '0) && !buf_bus.busy; // RULE10
      end
   end

   assign accept = trig && ready; // RULE5

   always_comb
   begin
      next_st           = st;
      next_st.exp_start = 1'b0;
      next_st.exp_done  = 1'b0;
      next_st.step_sync = {st.step_sync[MIT_SYNC_STAGES-2:0], step_pin};
      next_st.exp_sync  = {st.exp_sync[MIT_SYNC_STAGES-2:0], exposure_pin};
      if (st.step_sync[1] == st.step_sync[2])
      begin
         next_st.step_lvl = st.step_sync[2];
      end
      if (st.exp_sync[1] == st.exp_sync[2])
      begin
         next_st.exp_lvl = st.exp_sync[2];
      end
      case (st.acq)
         MIT_ACQ_READY:
         begin
            if (accept)
            begin
               next_st.exp_start = 1'b1; // RULE2
               next_st.acq       = MIT_ACQ_EXPOSE;
            end
         end
         MIT_ACQ_EXPOSE:
         begin
            if (exp_rise)
            begin
               next_st.exp_done = 1'b1; // RULE3
               next_st.acq      = MIT_ACQ_LOAD;
            end
         end
         MIT_ACQ_LOAD:
         begin
            if (load_done_in)
            begin
               next_st.acq = MIT_ACQ_READY; // RULE4
            end
         end
         default:
         begin
            next_st.acq = MIT_ACQ_READY;
         end
      endcase
      // Slot count: loaded images in, images moved to main memory out
      if (loaded && !buf_bus.img_take)
      begin
         next_st.count = st.count + CW'(1);
      end
      else if (!loaded && buf_bus.img_take && (st.count != '0))
      begin
         next_st.count = st.count - CW'(1);
      end
      // Freeing a slot is not enough; the running measurement must finish
      if (loaded && (next_st.count == CNT_MAX))
      begin
         next_st.full = 1'b1; // RULE6
      end
      else if (buf_bus.done)
      begin
         next_st.full = 1'b0; // RULE6
      end
      // An early trigger wins over a clear in the same cycle
      if (trig && !ready)
      begin
         next_st.err = 1'b1; // RULE7
      end
      else if (error_clear)
      begin
         next_st.err = 1'b0;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         st <= '{acq: MIT_ACQ_READY, count: '0, err: MIT_ERROR_RST, default: '0};
      end
      else
      begin
         st <= next_st;
      end
   end

   assign buf_bus.img_ready    = (st.count != '0);
   assign trigger_ready_status = ready; // RULE8
   assign error_out            = st.err;
   assign exposure_start       = st.exp_start;
   assign exposure_done_out    = st.exp_done;
   assign overlap_active       = ovl_ok;

   mit_proc_seq u_proc
   (
      .sys_clk      (sys_clk),
      .reset_n      (reset_n),
      .buf_bus      (buf_bus.proc),
      .xfer_start   (xfer_start),
      .xfer_done_in (xfer_done_in),
      .conv_start   (conv_start),
      .conv_done_in (conv_done_in),
      .meas_start   (meas_start),
      .meas_done_in (meas_done_in)
   );

   property p_drop_on_accept;
      @(posedge sys_clk) disable iff (!reset_n)
      accept |=> !ready throughout (st.acq != MIT_ACQ_READY);
   endproperty
   a_drop_on_accept: assert property (p_drop_on_accept) else $error("ready stayed high after a trigger"); // RULE12

   property p_start_needs_ready;
      @(posedge sys_clk) disable iff (!reset_n)
      exposure_start |-> $past(ready) && $past(trig);
   endproperty
   a_start_needs_ready: assert property (p_start_needs_ready) else $error("acquisition began without ready"); // RULE5

   property p_exposure_pulse;
      @(posedge sys_clk) disable iff (!reset_n)
      (st.acq == MIT_ACQ_EXPOSE) && exp_rise |=> exposure_done_out ##1 !exposure_done_out;
   endproperty
   a_exposure_pulse: assert property (p_exposure_pulse) else $error("exposure-done pulse missing"); // RULE3

   property p_ready_after_load;
      @(posedge sys_clk) disable iff (!reset_n)
      loaded && ovl_ok && !st.full && (st.count < CNT_MAX - CW'(1)) && !buf_bus.done
         |=> ready || $past(buf_bus.img_take) || !ovl_ok;
   endproperty
   a_ready_after_load: assert property (p_ready_after_load) else $error("ready not raised after load"); // RULE4 RULE1

   property p_err_on_early;
      @(posedge sys_clk) disable iff (!reset_n)
      trig && !ready |=> error_out [*2];
   endproperty
   a_err_on_early: assert property (p_err_on_early) else $error("early trigger did not flag error"); // RULE7

   property p_full_holds;
      @(posedge sys_clk) disable iff (!reset_n)
      st.full && !buf_bus.done |=> !ready;
   endproperty
   a_full_holds: assert property (p_full_holds) else $error("ready rose with image slots exhausted"); // RULE6

   property p_no_overlap;
      @(posedge sys_clk) disable iff (!reset_n)
      !ovl_ok && (buf_bus.busy || buf_bus.img_ready) |-> !ready;
   endproperty
   a_no_overlap: assert property (p_no_overlap) else $error("overlap used where not allowed"); // RULE10

   property p_overlap_ready;
      @(posedge sys_clk) disable iff (!reset_n)
      ovl_ok && buf_bus.busy && (st.acq == MIT_ACQ_READY) && !st.full && (st.count < CNT_MAX) |-> ready;
   endproperty
   a_overlap_ready: assert property (p_overlap_ready) else $error("ready held off during processing"); // RULE2

   c_overlap_accept: cover property (@(posedge sys_clk) disable iff (!reset_n) accept && buf_bus.busy);
   c_slots_full: cover property (@(posedge sys_clk) disable iff (!reset_n) $rose(st.full));
   c_early_trigger: cover property (@(posedge sys_clk) disable iff (!reset_n) trig && !ready);
   c_full_release: cover property (@(posedge sys_clk) disable iff (!reset_n) st.full ##1 !st.full ##[1:20] accept);

endmodule : mit_trigger_top

`default_nettype wire

// file: verif/mit_plc_model.sv
`timescale 1ns/1ps
`default_nettype none

// Trigger source standing in for the line controller.
// A forced request skips the ready gate, which the error scenario needs.
module mit_plc_model
(
   input  wire logic sys_clk,
   input  wire logic reset_n,
   input  wire logic trig_req,
   input  wire logic force_req,
   input  wire logic trigger_ready_status,
   output logic      cmd_trigger
);
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
         cmd_trigger <= 1'b0;
      else
         cmd_trigger <= force_req | (trig_req & trigger_ready_status);
   end
endmodule : mit_plc_model

`default_nettype wire

// file: verif/mit_trigger_top_tb.sv
`timescale 1ns/1ps
`default_nettype none

module mit_trigger_top_tb;
   import mit_pkg::*;
   logic       sys_clk, reset_n, step_pin, cmd_trigger, exposure_pin, load_done_in;
   logic       overlap_enable, error_clear, xfer_done_in, conv_done_in, meas_done_in;
   logic       trig_req, force_req;
   logic [4:0] inh;
   wire logic  ready, trigger_ready_status, error_out, exposure_start, exposure_done_out;
   wire logic  overlap_active, xfer_start, conv_start, meas_start;
   int         error_cnt, n_compared;

   mit_trigger_top #(.MAX_IMAGES(2)) u_mit_trigger_top
   (
      .sys_clk, .reset_n, .step_pin, .cmd_trigger, .exposure_pin, .load_done_in, .overlap_enable,
      .multi_camera_flow(inh[0]), .hdr_flow(inh[1]), .repeated_unit_flow(inh[2]),
      .serial_trigger_src(inh[3]), .builtin_light(inh[4]), .error_clear, .ready,
      .trigger_ready_status, .error_out, .exposure_start, .exposure_done_out, .overlap_active,
      .xfer_start, .xfer_done_in, .conv_start, .conv_done_in, .meas_start, .meas_done_in
   );

   mit_plc_model u_mit_plc_model
   (
      .sys_clk, .reset_n, .trig_req, .force_req, .trigger_ready_status, .cmd_trigger
   );

   initial
   begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   task end_of_test;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : end_of_test

   task chk(input string nm, input logic exp, input logic got);
      n_compared++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED %s expected %b seen %b", nm, exp, got);
      end
   endtask : chk

   // Pulses last one cycle, so every edge is sampled rather than waited on
   task wait_for(input int sel);
      logic hit;
      hit = 1'b0;
      // Look before waiting: a start pulse may already stand when the handshake returns
      repeat (20)
      begin
         hit = (sel == 0) ? exposure_start : (sel == 1) ? exposure_done_out :
               (sel == 2) ? xfer_start : (sel == 3) ? conv_start : meas_start;
         if (hit === 1'b1)
            break;
         @(posedge sys_clk);
         #1;
      end
      chk($sformatf("pulse %0d", sel), 1'b1, hit);
   endtask : wait_for

   task automatic pulse(ref logic s);
      s = 1'b1;
      @(posedge sys_clk);
      #1 s = 1'b0;
   endtask : pulse

   task start_trig;
      pulse(trig_req);
      wait_for(0);
      chk("ready after trigger", 1'b0, ready);
      chk("status bit", 1'b0, trigger_ready_status);
   endtask : start_trig

   task expose;
      exposure_pin = 1'b1;
      wait_for(1);
      exposure_pin = 1'b0;
      chk("ready before load", 1'b0, ready);
   endtask : expose

   task load(input logic exp);
      pulse(load_done_in);
      chk("ready after load", exp, ready);
   endtask : load

   task finish;
      pulse(xfer_done_in);
      wait_for(3);
      pulse(conv_done_in);
      wait_for(4);
      pulse(meas_done_in);
   endtask : finish

   task t_reset;
      chk("ready at reset", 1'b1, ready);
      chk("error at reset", 1'b0, error_out);
      chk("overlap usable", 1'b1, overlap_active);
   endtask : t_reset

   task t_overlap;
      start_trig();
      expose();
      load(1'b1);
      wait_for(2);
      start_trig();
      expose();
      load(1'b1);
      start_trig();
      expose();
      load(1'b0);
      chk("ready while full", 1'b0, ready);
      finish();
      wait_for(2);
      // The slot is released one cycle after the transfer starts
      @(posedge sys_clk) #1;
      chk("ready after full drains", 1'b1, ready);
      finish();
      wait_for(2);
      finish();
   endtask : t_overlap

   task t_error;
      start_trig();
      pulse(force_req);
      @(posedge sys_clk);
      #1;
      chk("early trigger skipped", 1'b0, exposure_start);
      @(posedge sys_clk);
      #1;
      chk("error raised", 1'b1, error_out);
      pulse(error_clear);
      chk("error cleared", 1'b0, error_out);
      expose();
      load(1'b1);
      wait_for(2);
      finish();
   endtask : t_error

   task t_step;
      step_pin = 1'b1;
      wait_for(0);
      chk("ready after step", 1'b0, ready);
      expose();
      step_pin = 1'b0;
      load(1'b1);
      wait_for(2);
      finish();
   endtask : t_step

   task t_no_overlap;
      for (int i = 0; i < 5; i++)
      begin
         inh = 5'h01 << i;
         @(posedge sys_clk) #1;
         chk($sformatf("inhibit %0d", i), 1'b0, overlap_active);
      end
      inh = 5'h00;
      overlap_enable = 1'b0;
      @(posedge sys_clk) #1;
      chk("overlap off", 1'b0, overlap_active);
      overlap_enable = 1'b1;
      inh = 5'h08;
      start_trig();
      expose();
      load(1'b0);
      wait_for(2);
      finish();
      repeat (2) @(posedge sys_clk);
      #1;
      chk("ready when idle", 1'b1, ready);
      inh = 5'h00;
   endtask : t_no_overlap

   initial
   begin
      repeat (5000) @(posedge sys_clk);
      error_cnt++;
      end_of_test();
   end

   initial
   begin
      {step_pin, exposure_pin, load_done_in, error_clear, trig_req, force_req} = '0;
      {xfer_done_in, conv_done_in, meas_done_in} = '0;
      inh = 5'h00;
      overlap_enable = 1'b1;
      reset_n = 1'b0;
      error_cnt = 0;
      n_compared = 0;
      repeat (2) @(posedge sys_clk);
      #1 reset_n = 1'b1;
      repeat (4) @(posedge sys_clk);
      #1;
      t_reset();
      t_overlap();
      t_error();
      t_step();
      t_no_overlap();
      end_of_test();
   end
endmodule : mit_trigger_top_tb

`default_nettype wire
